/* rtl/sbst_tap.sv */
// Boundary scan test port of a pipelined synchronous memory.
// Assumes the test clock is a separate clock from the memory clock, held
// low when unused, and that the memory core sits outside this block.
//
// Function
// - Sample on rising, drive on falling clock.
// - Undriven mode-select and data read high.
// - Serial in at MSB, out at LSB.
// - Output enabled by state, changes on falling.
// - Five high mode-selects reset; memory undisturbed.
// - Power-up reset leaves output at high impedance.
// - Instruction picks exactly one data register.
// - Three-bit instruction, preset to identification read.
// - Instruction capture loads 01 in low bits.
// - Bypass is one flop, captures low.
// - Boundary register captures ring, shifts in shift.
// - Identification value captured, then shifted out.
// - Instruction shifted, applied only at update.
// - All-zero code samples and floats memory outputs.
// - Test logic never drives the memory.
// - Output-disabling capture shifts ring, floats outputs.
// - Sample instruction snapshots pins at capture.
// - Bypass instruction shifts through the bypass flop.
`timescale 1ns/1ps
module sbst_tap #(
  parameter int          RING_W   = 36,
  parameter logic [31:0] ID_VALUE = 32'h0a5a_5001  // Arbitrary identification value.
) (
  // Memory clock domain.
  input  wire logic              core_clk_in,
  input  wire logic              sys_rst_in,
  // Test clock.
  input  wire logic              tck_in,
  // Serial test inputs with their driven flags.
  input  wire logic              tms_in,
  input  wire logic              tms_drv_in,
  input  wire logic              tdi_in,
  input  wire logic              tdi_drv_in,
  // Serial test output with its enable.
  output logic                   tdo_out,
  output logic                   tdo_oe_out,
  // Memory I/O ring levels to be observed.
  input  wire logic [RING_W-1:0] ring_in,
  // Request to hold the memory outputs at high impedance.
  output logic                   sram_hiz_out
);

  // Elaboration check on the ring width.
  if (RING_W < 2) begin : g_bad_ring
    $error("sbst_tap needs a ring of at least two bits");
  end

  // Test-domain wires.
  logic                  tap_rst;
  logic                  tms_eff;
  logic                  tdi_eff;
  logic [RING_W-1:0]     ring_sync;
  sbst_pkg::sbst_state_t state;
  sbst_pkg::sbst_dr_sel_t sel;

  // Instruction state.
  logic [2:0]            ir_reg;
  logic [2:0]            ir_next;
  logic [2:0]            irs_reg;
  logic [2:0]            irs_next;
  logic                  hiz_req_reg;
  logic                  hiz_req_next;

  // Data register state.
  logic                  byp_reg;
  logic                  byp_next;
  logic [RING_W-1:0]     bsr_reg;
  logic [RING_W-1:0]     bsr_next;
  logic [31:0]           id_reg;
  logic [31:0]           id_next;

  // Falling-edge output state.
  logic                  tdo_reg;
  logic                  tdo_next;
  logic                  tdo_oe_reg;
  logic                  tdo_oe_next;

  // Memory-domain state.
  logic                  hiz_sync;
  logic                  hiz_reg;
  logic                  hiz_next;

  // Memory reset carried into the test domain, used as power-up reset.
  sbst_sync #(
    .W (1)
  ) u_rst_sync (
    .clk_in (tck_in),
    .d_in   (sys_rst_in),
    .q_out  (tap_rst)
  );

  // Ring levels brought into the test domain before capture.
  sbst_sync #(
    .W (RING_W)
  ) u_ring_sync (
    .clk_in (tck_in),
    .d_in   (ring_in),
    .q_out  (ring_sync)
  );

  // Output-float request carried into the memory domain.
  sbst_sync #(
    .W (1)
  ) u_hiz_sync (
    .clk_in (core_clk_in),
    .d_in   (hiz_req_reg),
    .q_out  (hiz_sync)
  );

  // Pull-ups: an undriven input reads as high.
  assign tms_eff = tms_drv_in ? tms_in : sbst_pkg::PULL_LEVEL;
  assign tdi_eff = tdi_drv_in ? tdi_in : sbst_pkg::PULL_LEVEL;

  // Controller state machine.
  sbst_tap_fsm u_fsm (
    .tck_in     (tck_in),
    .tap_rst_in (tap_rst),
    .tms_in     (tms_eff),
    .state_out  (state)
  );

  // One data register is chosen from the applied instruction.
  assign sel = sbst_pkg::dr_select(ir_reg);

  // Instruction shifter and applied instruction.
  always_comb begin
    irs_next = irs_reg;
    ir_next  = ir_reg;
    case (state)
      sbst_pkg::ST_RESET: begin
        ir_next = sbst_pkg::INS_IDCODE;
      end
      sbst_pkg::ST_CAP_IR: begin
        irs_next = sbst_pkg::IR_CAPTURE;
      end
      sbst_pkg::ST_SHF_IR: begin
        irs_next = {tdi_eff, irs_reg[2:1]};
      end
      sbst_pkg::ST_UPD_IR: begin
        ir_next = irs_reg;
      end
      default: begin
        ir_next = ir_reg;
      end
    endcase
    hiz_req_next = sbst_pkg::forces_hiz(ir_next);
  end

  // Instruction registers sample on the rising test clock.
  always_ff @(posedge tck_in) begin
    if (tap_rst) begin
      ir_reg      <= sbst_pkg::INS_IDCODE;
      irs_reg     <= sbst_pkg::IR_CAPTURE;
      hiz_req_reg <= 1'b0;
    end else begin
      ir_reg      <= ir_next;
      irs_reg     <= irs_next;
      hiz_req_reg <= hiz_req_next;
    end
  end

  // Data registers: capture and shift only the register that is chosen.
  // Update has no effect: the ring is observed, never driven.
  always_comb begin
    byp_next = byp_reg;
    bsr_next = bsr_reg;
    id_next  = id_reg;
    if (state == sbst_pkg::ST_CAP_DR) begin
      case (sel)
        sbst_pkg::SEL_BSR: bsr_next = ring_sync;
        sbst_pkg::SEL_ID:  id_next  = ID_VALUE;
        default:           byp_next = sbst_pkg::BYP_CAPTURE;
      endcase
    end else if (state == sbst_pkg::ST_SHF_DR) begin
      case (sel)
        sbst_pkg::SEL_BSR: bsr_next = {tdi_eff, bsr_reg[RING_W-1:1]};
        sbst_pkg::SEL_ID:  id_next  = {tdi_eff, id_reg[31:1]};
        default:           byp_next = tdi_eff;
      endcase
    end
  end

  // Data registers sample on the rising test clock.
  always_ff @(posedge tck_in) begin
    if (tap_rst) begin
      byp_reg <= sbst_pkg::BYP_CAPTURE;
      bsr_reg <= '0;
      id_reg  <= '0;
    end else begin
      byp_reg <= byp_next;
      bsr_reg <= bsr_next;
      id_reg  <= id_next;
    end
  end

  // Serial output: the least significant bit of the path, enabled only while shifting.
  always_comb begin
    tdo_oe_next = (state == sbst_pkg::ST_SHF_DR) || (state == sbst_pkg::ST_SHF_IR);
    if (state == sbst_pkg::ST_SHF_IR) begin
      tdo_next = irs_reg[0];
    end else begin
      case (sel)
        sbst_pkg::SEL_BSR: tdo_next = bsr_reg[0];
        sbst_pkg::SEL_ID:  tdo_next = id_reg[0];
        default:           tdo_next = byp_reg;
      endcase
    end
  end

  // Output flops change only on the falling test clock.
  always_ff @(negedge tck_in) begin
    if (tap_rst) begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else begin
      tdo_reg    <= tdo_next;
      tdo_oe_reg <= tdo_oe_next;
    end
  end

  // Serial output pins come straight from the falling-edge flops.
  assign tdo_out    = tdo_reg;
  assign tdo_oe_out = tdo_oe_reg;

  // Memory-domain output float request; the test reset never touches it
  // beyond the request level, so memory accesses carry on undisturbed.
  always_comb begin
    hiz_next = hiz_sync;
  end

  // Memory-domain register.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      hiz_reg <= 1'b0;
    end else begin
      hiz_reg <= hiz_next;
    end
  end

  // The float request leaves the block from the memory-domain flop.
  assign sram_hiz_out = hiz_reg;

  // Checks in the test clock domain.
  a_reset_loads_idcode: assert property (@(posedge tck_in) disable iff (tap_rst)
    state == sbst_pkg::ST_RESET |=> ir_reg == sbst_pkg::INS_IDCODE)
    else $error("reset state did not preset the identification instruction");

  a_capture_ir_pattern: assert property (@(posedge tck_in) disable iff (tap_rst)
    state == sbst_pkg::ST_CAP_IR |=> irs_reg[1:0] == sbst_pkg::IR_CAPTURE[1:0])
    else $error("instruction capture did not load the fixed pattern");

  a_update_applies_ir: assert property (@(posedge tck_in) disable iff (tap_rst)
    state == sbst_pkg::ST_UPD_IR |=> ir_reg == $past(irs_reg))
    else $error("update did not apply the shifted instruction");

  a_ir_held_otherwise: assert property (@(posedge tck_in) disable iff (tap_rst)
    (state != sbst_pkg::ST_UPD_IR && state != sbst_pkg::ST_RESET) |=> $stable(ir_reg))
    else $error("instruction changed outside update or reset");

  a_bypass_capture_low: assert property (@(posedge tck_in) disable iff (tap_rst)
    (state == sbst_pkg::ST_CAP_DR && sel == sbst_pkg::SEL_BYPASS) |=> byp_reg == 1'b0)
    else $error("bypass flop not cleared on capture");

  a_id_capture_value: assert property (@(posedge tck_in) disable iff (tap_rst)
    (state == sbst_pkg::ST_CAP_DR && sel == sbst_pkg::SEL_ID) |=> id_reg == ID_VALUE)
    else $error("identification value not captured");

  a_ring_capture: assert property (@(posedge tck_in) disable iff (tap_rst)
    (state == sbst_pkg::ST_CAP_DR && sel == sbst_pkg::SEL_BSR) |=> bsr_reg == $past(ring_sync))
    else $error("boundary register did not capture the ring");

  a_shift_into_msb: assert property (@(posedge tck_in) disable iff (tap_rst)
    (state == sbst_pkg::ST_SHF_DR && sel == sbst_pkg::SEL_ID) |=> id_reg[31] == $past(tdi_eff))
    else $error("serial input did not enter the most significant bit");

  a_tdo_enable_state: assert property (@(posedge tck_in) disable iff (tap_rst)
    ##1 tdo_oe_out == (state == sbst_pkg::ST_SHF_DR || state == sbst_pkg::ST_SHF_IR))
    else $error("serial output enable does not follow the shift states");

  a_hiz_follows_ins: assert property (@(posedge tck_in) disable iff (tap_rst)
    state == sbst_pkg::ST_UPD_IR |=> hiz_req_reg == sbst_pkg::forces_hiz($past(irs_reg)))
    else $error("output float request does not match the new instruction");

  a_ir_shift_msb: assert property (@(posedge tck_in) disable iff (tap_rst)
    state == sbst_pkg::ST_SHF_IR |=> irs_reg[2] == $past(tdi_eff))
    else $error("serial input did not enter the instruction shifter top bit");

  a_ring_shift_msb: assert property (@(posedge tck_in) disable iff (tap_rst)
    (state == sbst_pkg::ST_SHF_DR && sel == sbst_pkg::SEL_BSR) |=>
      bsr_reg[RING_W-1] == $past(tdi_eff))
    else $error("serial input did not enter the boundary register top bit");

  a_bypass_shift: assert property (@(posedge tck_in) disable iff (tap_rst)
    (state == sbst_pkg::ST_SHF_DR && sel == sbst_pkg::SEL_BYPASS) |=>
      byp_reg == $past(tdi_eff))
    else $error("bypass flop did not take the serial input");

  a_tdo_shows_lsb: assert property (@(posedge tck_in) disable iff (tap_rst)
    (state == sbst_pkg::ST_SHF_DR && sel == sbst_pkg::SEL_ID) |-> tdo_out == id_reg[0])
    else $error("serial output does not show the identification bottom bit");

endmodule

/* shared/sbst_pkg.sv */
// Shared constants and types of the boundary scan test port.
// Assumes one test port per memory and a single instruction decode.
package sbst_pkg;

  // Test port state machine states, sixteen of them.
  typedef enum logic [3:0] {
    ST_RESET   = 4'h0,
    ST_IDLE    = 4'h1,
    ST_SEL_DR  = 4'h2,
    ST_CAP_DR  = 4'h3,
    ST_SHF_DR  = 4'h4,
    ST_EX1_DR  = 4'h5,
    ST_PAU_DR  = 4'h6,
    ST_EX2_DR  = 4'h7,
    ST_UPD_DR  = 4'h8,
    ST_SEL_IR  = 4'h9,
    ST_CAP_IR  = 4'ha,
    ST_SHF_IR  = 4'hb,
    ST_EX1_IR  = 4'hc,
    ST_PAU_IR  = 4'hd,
    ST_EX2_IR  = 4'he,
    ST_UPD_IR  = 4'hf
  } sbst_state_t;

  // Instruction register width and instruction codes.
  localparam int          IR_W         = 3;
  localparam logic [2:0]  INS_EXTEST   = 3'h0;
  localparam logic [2:0]  INS_IDCODE   = 3'h1;
  localparam logic [2:0]  INS_SAMPLE_Z = 3'h2;
  localparam logic [2:0]  INS_SAMPLE   = 3'h4;
  localparam logic [2:0]  INS_BYPASS   = 3'h7;

  // Pattern loaded into the instruction shifter on capture.
  localparam logic [2:0]  IR_CAPTURE   = 3'h1;

  // Identification register width and bypass capture value.
  localparam int          ID_W         = 32;
  localparam logic        BYP_CAPTURE  = 1'b0;

  // Level that an undriven mode-select or data input reads as.
  localparam logic        PULL_LEVEL   = 1'b1;

  // Data register chosen by the current instruction.
  typedef enum logic [1:0] {
    SEL_BYPASS = 2'h0,
    SEL_BSR    = 2'h1,
    SEL_ID     = 2'h2
  } sbst_dr_sel_t;

  // Maps an instruction onto exactly one data register.
  function automatic sbst_dr_sel_t dr_select(input logic [2:0] ins);
    case (ins)
      INS_EXTEST, INS_SAMPLE_Z, INS_SAMPLE: dr_select = SEL_BSR;
      INS_IDCODE:                           dr_select = SEL_ID;
      default:                              dr_select = SEL_BYPASS;
    endcase
  endfunction

  // True for instructions that hold the memory outputs at high impedance.
  function automatic logic forces_hiz(input logic [2:0] ins);
    forces_hiz = (ins == INS_EXTEST) || (ins == INS_SAMPLE_Z);
  endfunction

endpackage

/* rtl/sbst_sync.sv */
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; multi-bit words may tear for one cycle.
`timescale 1ns/1ps
module sbst_sync #(
  parameter int W = 1
) (
  // Destination clock.
  input  wire logic         clk_in,
  // Asynchronous levels.
  input  wire logic [W-1:0] d_in,
  // Synchronised levels.
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  // Elaboration check on the width.
  if (W < 1) begin : g_bad_width
    $error("sbst_sync needs a width of at least one");
  end

  // The first stage feeds only the second stage.
  always_comb begin
    meta_next = d_in;
    q_next    = meta_reg;
  end

  // Both stages run on every rising edge with no reset.
  always_ff @(posedge clk_in) begin
    meta_reg <= meta_next;
    q_out    <= q_next;
  end

endmodule

/* rtl/sbst_tap_fsm.sv */
// Sixteen-state test port controller advanced by the test clock.
// Assumes mode-select is already resolved for its pull-up.
`timescale 1ns/1ps
module sbst_tap_fsm (
  // Test clock and test-domain reset.
  input  wire logic                 tck_in,
  input  wire logic                 tap_rst_in,
  // Resolved mode-select level.
  input  wire logic                 tms_in,
  // Current state.
  output sbst_pkg::sbst_state_t     state_out
);

  sbst_pkg::sbst_state_t state_reg;
  sbst_pkg::sbst_state_t state_next;

  assign state_out = state_reg;

  // Next state from the sampled mode-select value.
  always_comb begin
    case (state_reg)
      sbst_pkg::ST_RESET:  state_next = tms_in ? sbst_pkg::ST_RESET  : sbst_pkg::ST_IDLE;
      sbst_pkg::ST_IDLE:   state_next = tms_in ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
      sbst_pkg::ST_SEL_DR: state_next = tms_in ? sbst_pkg::ST_SEL_IR : sbst_pkg::ST_CAP_DR;
      sbst_pkg::ST_CAP_DR: state_next = tms_in ? sbst_pkg::ST_EX1_DR : sbst_pkg::ST_SHF_DR;
      sbst_pkg::ST_SHF_DR: state_next = tms_in ? sbst_pkg::ST_EX1_DR : sbst_pkg::ST_SHF_DR;
      sbst_pkg::ST_EX1_DR: state_next = tms_in ? sbst_pkg::ST_UPD_DR : sbst_pkg::ST_PAU_DR;
      sbst_pkg::ST_PAU_DR: state_next = tms_in ? sbst_pkg::ST_EX2_DR : sbst_pkg::ST_PAU_DR;
      sbst_pkg::ST_EX2_DR: state_next = tms_in ? sbst_pkg::ST_UPD_DR : sbst_pkg::ST_SHF_DR;
      sbst_pkg::ST_UPD_DR: state_next = tms_in ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
      sbst_pkg::ST_SEL_IR: state_next = tms_in ? sbst_pkg::ST_RESET  : sbst_pkg::ST_CAP_IR;
      sbst_pkg::ST_CAP_IR: state_next = tms_in ? sbst_pkg::ST_EX1_IR : sbst_pkg::ST_SHF_IR;
      sbst_pkg::ST_SHF_IR: state_next = tms_in ? sbst_pkg::ST_EX1_IR : sbst_pkg::ST_SHF_IR;
      sbst_pkg::ST_EX1_IR: state_next = tms_in ? sbst_pkg::ST_UPD_IR : sbst_pkg::ST_PAU_IR;
      sbst_pkg::ST_PAU_IR: state_next = tms_in ? sbst_pkg::ST_EX2_IR : sbst_pkg::ST_PAU_IR;
      sbst_pkg::ST_EX2_IR: state_next = tms_in ? sbst_pkg::ST_UPD_IR : sbst_pkg::ST_SHF_IR;
      sbst_pkg::ST_UPD_IR: state_next = tms_in ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
      default:             state_next = sbst_pkg::ST_RESET;
    endcase
  end

  // State register, forced to the reset state by the test-domain reset.
  always_ff @(posedge tck_in) begin
    if (tap_rst_in) begin
      state_reg <= sbst_pkg::ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Five rising edges with mode-select high always land in the reset state.
  a_five_high_reset: assert property (@(posedge tck_in) disable iff (tap_rst_in)
    tms_in [*5] |=> state_reg == sbst_pkg::ST_RESET)
    else $error("five high mode-select samples did not reach reset");

  // The reset state left with mode-select low goes to idle.
  a_low_leaves_reset: assert property (@(posedge tck_in) disable iff (tap_rst_in)
    (state_reg == sbst_pkg::ST_RESET && !tms_in) |=> state_reg == sbst_pkg::ST_IDLE)
    else $error("reset state with mode-select low did not go idle");

endmodule

/* tb/sbst_ctl_model.sv */
// Behavioural boundary scan controller that drives the test port pins.
// Assumes the bench calls its tasks one at a time; the clock idles low between them.
`timescale 1ns/1ps
module sbst_ctl_model (
  // Test clock and serial pins toward the port.
  output logic     tck_out,
  output logic     tms_out,
  output logic     tms_drv_out,
  output logic     tdi_out,
  output logic     tdi_drv_out,
  // Serial data returned by the port.
  input  wire logic tdo_in,
  input  wire logic tdo_oe_in
);
  // The clock rests low whenever no frame is running.
  initial begin
    tck_out     = 1'b0;
    tms_out     = 1'b1;
    tms_drv_out = 1'b1;
    tdi_out     = 1'b1;
    tdi_drv_out = 1'b1;
  end

  // One clock period: drive after the fall, sample the output at the rise.
  // A released pin shows a toggling level, so only a working pull-up reads high.
  task automatic step(input logic m, input logic d, input logic dm, input logic dd,
                      output logic o, output logic e);
    #1;
    tms_drv_out = dm;
    tdi_drv_out = dd;
    tms_out     = dm ? m : ~tms_out;
    tdi_out     = dd ? d : ~tdi_out;
    #14;
    o       = tdo_in;
    e       = tdo_oe_in;
    tck_out = 1'b1;
    #15;
    tck_out = 1'b0;
  endtask

  // Walks from idle into a shift state, shifts n bits, and stops in the exit state.
  task automatic scan(input bit ir, input int n, input logic [95:0] din, input logic dd,
                      output logic [95:0] dout, output bit oe_ok);
    logic o;
    logic e;
    oe_ok = 1'b1;
    dout  = '0;
    step(1'b1, 1'b0, 1'b1, 1'b1, o, e);
    if (ir) step(1'b1, 1'b0, 1'b1, 1'b1, o, e);
    step(1'b0, 1'b0, 1'b1, 1'b1, o, e);
    step(1'b0, 1'b0, 1'b1, 1'b1, o, e);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], 1'b1, dd, o, e);
      dout[i] = o;
      oe_ok   = oe_ok & (e === 1'b1);
    end
  endtask

  // Passes through the update state back to idle; e is the enable seen in the exit state.
  task automatic leave(output logic e);
    logic o;
    logic e2;
    step(1'b1, 1'b0, 1'b1, 1'b1, o, e);
    step(1'b0, 1'b0, 1'b1, 1'b1, o, e2);
  endtask
endmodule

/* tb/tb_sbst_tap.sv */
// Self-checking bench of the boundary scan test port, with a queue model of the scan path.
// Assumes the controller model drives all test pins; the bench owns reset and the ring.
`timescale 1ns/1ps
module tb_sbst_tap;
  localparam int          RING_W   = 36;
  localparam logic [31:0] ID_VALUE = 32'h1357_9bdf; // Arbitrary identification value.

  logic              core_clk_in = 1'b0;
  logic              sys_rst_in  = 1'b1;
  logic [RING_W-1:0] ring_in     = '0;
  logic              tck, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe, hiz;
  logic              hiz_exp     = 1'b0;
  int                bad_count   = 0;
  int                checked     = 0;
  int                seed        = 98801;

  // Memory clock at 125 MHz.
  always #4 core_clk_in = ~core_clk_in;

  sbst_tap #(.RING_W(RING_W), .ID_VALUE(ID_VALUE)) i_dut (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .tck_in(tck), .tms_in(tms),
    .tms_drv_in(tms_drv), .tdi_in(tdi), .tdi_drv_in(tdi_drv), .tdo_out(tdo),
    .tdo_oe_out(tdo_oe), .ring_in(ring_in), .sram_hiz_out(hiz));

  sbst_ctl_model i_ctl (
    .tck_out(tck), .tms_out(tms), .tms_drv_out(tms_drv), .tdi_out(tdi),
    .tdi_drv_out(tdi_drv), .tdo_in(tdo), .tdo_oe_in(tdo_oe));

  // Compares a shifted-out stream with the model.
  task automatic cmp_stream(input logic [95:0] got, input logic [95:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares a single level with the model.
  task automatic cmp_level(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Loads a code through a six-bit shift; the top three bits land in the register.
  task automatic ir_load(input logic [2:0] code);
    logic [95:0] din;
    logic [95:0] dout;
    bit          ok;
    logic        e;
    din = {90'h0, code, 3'($random(seed))};
    i_ctl.scan(1'b1, 6, din, 1'b1, dout, ok);
    cmp_stream(dout, {90'h0, din[2:0], 3'b001});
    cmp_level(ok, 1'b1);
    repeat (4) @(negedge core_clk_in);
    cmp_level(hiz, hiz_exp);
    i_ctl.leave(e);
    cmp_level(e, 1'b0);
    hiz_exp = (code == 3'h0) || (code == 3'h2);
    repeat (4) @(negedge core_clk_in);
    cmp_level(hiz, hiz_exp);
  endtask

  // Captures and shifts len+8 bits; the model queue holds captured bits then delayed input.
  task automatic dr_check(input logic [2:0] code, input logic dd);
    logic [95:0]       din;
    logic [95:0]       dout;
    logic [95:0]       exp;
    logic [95:0]       cap;
    logic [RING_W-1:0] r;
    logic              q[$];
    int                len;
    bit                ok;
    logic              e;
    r = RING_W'({$random(seed), $random(seed)});
    @(posedge core_clk_in);
    ring_in <= r;
    i_ctl.step(1'b0, 1'b0, 1'b1, 1'b1, e, e);
    i_ctl.step(1'b0, 1'b0, 1'b1, 1'b1, e, e);
    case (code)
      3'h0, 3'h2, 3'h4: begin
        len = RING_W;
        cap = {60'h0, r};
      end
      3'h1: begin
        len = 32;
        cap = {64'h0, ID_VALUE};
      end
      default: begin
        len = 1;
        cap = '0;
      end
    endcase
    din = {$random(seed), $random(seed), $random(seed)};
    exp = '0;
    for (int i = 0; i < len; i++) q.push_back(cap[i]);
    for (int i = 0; i < 8; i++) q.push_back(dd ? din[i] : 1'b1);
    for (int i = 0; i < len + 8; i++) exp[i] = q.pop_front();
    i_ctl.scan(1'b0, len + 8, din, dd, dout, ok);
    cmp_stream(dout, exp);
    cmp_level(ok, 1'b1);
    i_ctl.leave(e);
    cmp_level(e, 1'b0);
  endtask

  // The serial output may only move while the test clock is low.
  always @(tdo or tdo_oe) begin
    cmp_level(tck, 1'b0);
  end

  // Main sequence.
  initial begin
    logic       o;
    logic       e;
    logic [2:0] codes [5];
    codes = '{3'h7, 3'h0, 3'h2, 3'h4, 3'h1};
    repeat (6) i_ctl.step(1'b1, 1'b1, 1'b1, 1'b1, o, e);
    cmp_level(e, 1'b0);
    cmp_level(hiz, 1'b0);
    @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    repeat (4) i_ctl.step(1'b1, 1'b1, 1'b1, 1'b1, o, e);
    i_ctl.step(1'b0, 1'b0, 1'b1, 1'b1, o, e);
    dr_check(3'h1, 1'b1);
    $display("test power-up identification done");
    foreach (codes[k]) begin
      ir_load(codes[k]);
      dr_check(codes[k], 1'b1);
      $display("test instruction %h done", codes[k]);
    end
    ir_load(3'h0);
    repeat (5) i_ctl.step(1'b0, 1'b0, 1'b0, 1'b1, o, e);
    hiz_exp = 1'b0;
    repeat (4) @(negedge core_clk_in);
    cmp_level(hiz, hiz_exp);
    i_ctl.step(1'b0, 1'b0, 1'b1, 1'b1, o, e);
    dr_check(3'h1, 1'b0);
    $display("test mode-select reset done");
    summarize();
  end

  // Watchdog: the sequence needs some 12 us of simulated time.
  initial begin
    #200000;
    bad_count++;
    summarize();
  end
endmodule
